// ---- hw/dllsw_params.svh ----
// Constants for the DLL switch, frequency change and write-leveling feedback block.
// Assumes the controller-side clock domain clk_sys at 20 MHz and a plain register port.
// Function
// - MR1 A0 high disables the DLL until written back low.
// - Device ignores clock after self-refresh entry plus tCKSRE; new clock in range.
// - In leveling, sample clock on strobe rising edge and return it on data.
// - Each byte lane has its own feedback: DQ0 lower lane, DQ8 upper lane.
// - MR1 A7 high enters write leveling; low leaves it.
`ifndef DLLSW_PARAMS_SVH
`define DLLSW_PARAMS_SVH

// Register indices on the plain port
`define DLLSW_REG_CTRL 4'h0
`define DLLSW_REG_STATUS 4'h1
`define DLLSW_REG_LOCKCFG 4'h2

// Mode register field positions
`define DLLSW_MR1_DLL_OFF_BIT 0
`define DLLSW_MR1_WLEV_BIT 7
`define DLLSW_MR0_DLL_RST_BIT 8

// Mode register select codes
`define DLLSW_MRS_MR0 2'h0
`define DLLSW_MR1_SEL 2'h1

// DLL lock time in clock cycles (default)
`define DLLSW_DLLK_CYCLES 16'h0200
// Clock-ignore delay after self-refresh entry, in ns, and derived cycles
`define DLLSW_CKSRE_NS 10
`define DLLSW_CLK_NS 50
`define DLLSW_CKSRE_CYC ((`DLLSW_CKSRE_NS + `DLLSW_CLK_NS - 1) / `DLLSW_CLK_NS)

`endif

// ---- hw/dllsw_pkg.sv ----
// Types for the DLL switch block.
// Assumes dllsw_params.svh supplies the numeric constants.
package dllsw_pkg;
  typedef enum logic [1:0] {
    DLLSW_PWR_ACTIVE,
    DLLSW_PWR_SELF_REFRESH,
    DLLSW_PWR_PRE_PD
  } dllsw_pwr_e;

  typedef enum logic [1:0] {
    DLLSW_DLL_OFF,
    DLLSW_DLL_RELOCK,
    DLLSW_DLL_LOCKED
  } dllsw_dll_e;
endpackage

// ---- hw/dllsw_core.sv ----
// DRAM-side DLL state, clock-ignore tracking and write-leveling feedback.
// Assumes decoded mode writes and power-state events from the command decoder,
// and strobe pairs already resolved to single-ended levels synchronous to clk_sys.
`timescale 1ns/1ps
`include "dllsw_params.svh"
module dllsw_core #(
  parameter logic [15:0] DLLK_CYCLES = `DLLSW_DLLK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Decoded command events
  input wire logic mrs_strobe,
  input wire logic [1:0] mrs_select,
  input wire logic [15:0] mrs_value,
  input wire logic sr_enter,
  input wire logic sr_exit,
  input wire logic pd_enter,
  input wire logic pd_exit,
  // Differential clock and strobes
  input wire logic ck_level,
  input wire logic lower_lane_strobe_pair,
  input wire logic upper_lane_strobe_pair,
  // Leveling feedback on the data bus
  output logic dq0_out,
  output logic dq0_oe,
  output logic dq8_out,
  output logic dq8_oe,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Status
  output logic dll_disabled,
  output logic wlev_active,
  output logic clk_ignored
);

  logic dll_off;
  logic wlev;
  dllsw_pkg::dllsw_pwr_e pwr;
  dllsw_pkg::dllsw_dll_e dll_st;
  logic [15:0] lock_cnt;
  logic [15:0] lock_cfg;
  logic [7:0] cksre_cnt;
  logic ignore;
  logic lstb_q;
  logic ustb_q;
  logic [15:0] mr1_shadow;
  logic [7:0] sample_count;

  function automatic logic rising(input logic now, input logic prev);
    rising = now & ~prev;
  endfunction

  // Mode register 1 holds both DLL-off and leveling enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dll_off <= 1'b0;
      wlev <= 1'b0;
      mr1_shadow <= 16'h0000;
    end else if (mrs_strobe && mrs_select == `DLLSW_MR1_SEL) begin
      dll_off <= mrs_value[`DLLSW_MR1_DLL_OFF_BIT];
      wlev <= mrs_value[`DLLSW_MR1_WLEV_BIT];
      mr1_shadow <= mrs_value;
    end
  end

  // Power state for clock-change windows
  // Entry pulses count only from the active state; other states wait for their exit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwr <= dllsw_pkg::DLLSW_PWR_ACTIVE;
    end else begin
      case (pwr)
        dllsw_pkg::DLLSW_PWR_ACTIVE: begin
          if (sr_enter) begin
            pwr <= dllsw_pkg::DLLSW_PWR_SELF_REFRESH;
          end else if (pd_enter) begin
            pwr <= dllsw_pkg::DLLSW_PWR_PRE_PD;
          end
        end
        dllsw_pkg::DLLSW_PWR_SELF_REFRESH: begin
          if (sr_exit) begin
            pwr <= dllsw_pkg::DLLSW_PWR_ACTIVE;
          end
        end
        default: begin
          if (pd_exit) begin
            pwr <= dllsw_pkg::DLLSW_PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  // Clock becomes don't-care once tCKSRE passes after entry
  // The counter saturates, so a long stay in a low-power state cannot wrap it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cksre_cnt <= 8'h00;
      ignore <= 1'b0;
    end else if (pwr == dllsw_pkg::DLLSW_PWR_ACTIVE) begin
      cksre_cnt <= 8'h00;
      ignore <= 1'b0;
    end else if (cksre_cnt >= 8'(`DLLSW_CKSRE_CYC)) begin
      ignore <= 1'b1;
    end else begin
      cksre_cnt <= cksre_cnt + 8'h01;
    end
  end

  // DLL relock after reset; a clock change while the DLL runs forces relock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dll_st <= dllsw_pkg::DLLSW_DLL_OFF;
      lock_cnt <= 16'h0000;
    end else if (dll_off) begin
      // A0 set overrides any reset command or clock event
      dll_st <= dllsw_pkg::DLLSW_DLL_OFF;
      lock_cnt <= 16'h0000;
    end else if (mrs_strobe && mrs_select == `DLLSW_MRS_MR0
                 && mrs_value[`DLLSW_MR0_DLL_RST_BIT]) begin
      dll_st <= dllsw_pkg::DLLSW_DLL_RELOCK;
      lock_cnt <= lock_cfg;
    end else if (dll_st == dllsw_pkg::DLLSW_DLL_RELOCK) begin
      if (lock_cnt == 16'h0000) begin
        dll_st <= dllsw_pkg::DLLSW_DLL_LOCKED;
      end else begin
        lock_cnt <= lock_cnt - 16'h0001;
      end
    end else if (ignore) begin
      // The clock may have moved while ignored, so the old lock is not trusted
      dll_st <= dllsw_pkg::DLLSW_DLL_RELOCK;
      lock_cnt <= lock_cfg;
    end
  end

  // Strobe edge detection
  // Idle strobe level is low, so the reset value leaves no false edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lstb_q <= 1'b0;
      ustb_q <= 1'b0;
    end else begin
      lstb_q <= lower_lane_strobe_pair;
      ustb_q <= upper_lane_strobe_pair;
    end
  end

  // Per-lane feedback: sampled clock returned on the prime bit of each lane.
  // Sampling at clk_sys granularity trades edge precision for a fully synchronous design.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dq0_out <= 1'b0;
      dq8_out <= 1'b0;
      dq0_oe <= 1'b0;
      dq8_oe <= 1'b0;
      sample_count <= 8'h00;
    end else if (wlev) begin
      dq0_oe <= 1'b1;
      dq8_oe <= 1'b1;
      if (rising(lower_lane_strobe_pair, lstb_q)) begin
        dq0_out <= ck_level;
        sample_count <= sample_count + 8'h01;
      end
      if (rising(upper_lane_strobe_pair, ustb_q)) begin
        dq8_out <= ck_level;
      end
    end else begin
      dq0_oe <= 1'b0;
      dq8_oe <= 1'b0;
      dq0_out <= 1'b0;
      dq8_out <= 1'b0;
    end
  end

  // Register port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_cfg <= DLLK_CYCLES;
    end else if (reg_wr && reg_addr == `DLLSW_REG_LOCKCFG) begin
      lock_cfg <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      // Unmapped indices read as zero rather than aliasing a real register
      if (reg_addr == `DLLSW_REG_CTRL) begin
        reg_rdata <= {16'h0000, mr1_shadow};
      end else if (reg_addr == `DLLSW_REG_STATUS) begin
        reg_rdata <= {sample_count, 8'h00, 8'h00, 1'b0, ignore, pwr, dll_st, wlev, dll_off};
      end else if (reg_addr == `DLLSW_REG_LOCKCFG) begin
        reg_rdata <= {16'h0000, lock_cfg};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Status outputs
  // They lag the internal state by one cycle so that every pin comes from a flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dll_disabled <= 1'b0;
      wlev_active <= 1'b0;
      clk_ignored <= 1'b0;
    end else begin
      dll_disabled <= dll_off;
      wlev_active <= wlev;
      clk_ignored <= ignore;
    end
  end

endmodule

// ---- verif/dllsw_core_assertions.sv ----
// Port checks for dllsw_core.
// Assumes one clock, clk_sys, and asynchronous reset arst_n.
`timescale 1ns/1ps
`include "dllsw_params.svh"
module dllsw_core_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Inputs
  input wire logic mrs_strobe,
  input wire logic [1:0] mrs_select,
  input wire logic [15:0] mrs_value,
  input wire logic sr_enter,
  input wire logic ck_level,
  input wire logic lower_lane_strobe_pair,
  input wire logic upper_lane_strobe_pair,
  // Outputs
  input wire logic dq0_out,
  input wire logic dq0_oe,
  input wire logic dq8_out,
  input wire logic dq8_oe,
  input wire logic dll_disabled,
  input wire logic wlev_active,
  input wire logic clk_ignored
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire logic mr1 = mrs_strobe && mrs_select == `DLLSW_MR1_SEL;
  a_dll_follow: assert property (mr1 |-> ##2 dll_disabled == $past(mrs_value[0], 2))
    else $error("dll_disabled off MR1 bit 0");
  a_dll_hold: assert property ($changed(dll_disabled) |-> $past(mr1, 2))
    else $error("dll_disabled moved without MR1 write");
  a_wlev_follow: assert property (mr1 |-> ##2 wlev_active == $past(mrs_value[7], 2))
    else $error("wlev_active off MR1 bit 7");
  a_lower_fb: assert property (wlev_active && $rose(lower_lane_strobe_pair) |=>
    dq0_out == $past(ck_level)) else $error("dq0 feedback wrong");
  a_upper_fb: assert property (wlev_active && $rose(upper_lane_strobe_pair) |=>
    dq8_out == $past(ck_level)) else $error("dq8 feedback wrong");
  a_oe_on: assert property (wlev_active && $past(wlev_active) |-> dq0_oe && dq8_oe)
    else $error("feedback not driven");
  a_oe_off: assert property (!wlev_active && !$past(wlev_active) |-> !dq0_oe && !dq8_oe)
    else $error("feedback driven outside leveling");
  a_sr_ignore: assert property (sr_enter |-> ##[1:4] clk_ignored)
    else $error("clock not ignored after entry");
  cover property (mr1 ##2 dll_disabled);
  cover property (wlev_active && $rose(upper_lane_strobe_pair));
  cover property (sr_enter ##[1:4] clk_ignored);
endmodule
bind dllsw_core dllsw_core_assertions u_chk (.clk_sys, .arst_n, .mrs_strobe, .mrs_select,
  .mrs_value, .sr_enter, .ck_level, .lower_lane_strobe_pair, .upper_lane_strobe_pair,
  .dq0_out, .dq0_oe, .dq8_out, .dq8_oe, .dll_disabled, .wlev_active, .clk_ignored);

// ---- verif/dllsw_ctrl_model.sv ----
// Memory-controller model: mode writes, power events, CK level, strobes.
// Assumes the bench calls one task at a time; all changes follow clk_sys edges.
`timescale 1ns/1ps
module dllsw_ctrl_model #(
  parameter int T_MOD = 12,
  parameter int T_CKSRX = 5
) (
  // Clock
  input wire logic clk_sys,
  // Toward the device
  output logic mrs_strobe,
  output logic [1:0] mrs_select,
  output logic [15:0] mrs_value,
  output logic [3:0] pwr_ev,
  output logic ck_level,
  output logic [1:0] stb
);
  initial {mrs_strobe, mrs_select, mrs_value, pwr_ev, ck_level, stb} = '0;
  // Released mode bus is scrambled so a stale value is never mistaken for data
  task automatic mrs(input logic [1:0] sel, input logic [15:0] val);
    @(posedge clk_sys);
    mrs_strobe <= 1'b1;
    mrs_select <= sel;
    mrs_value <= val;
    @(posedge clk_sys);
    mrs_strobe <= 1'b0;
    mrs_value <= ~val;
    repeat (T_MOD) @(posedge clk_sys);
  endtask
  task automatic pwr(input logic [3:0] ev);
    @(posedge clk_sys);
    pwr_ev <= ev;
    @(posedge clk_sys);
    pwr_ev <= 4'h0;
    repeat (T_CKSRX) @(posedge clk_sys);
  endtask
  // Only strobes, no commands, while leveling
  task automatic pulse(input int lane, input logic ck);
    @(posedge clk_sys);
    ck_level <= ck;
    @(posedge clk_sys);
    stb[lane] <= 1'b1;
    @(posedge clk_sys);
    stb[lane] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

// ---- verif/tb_dll_switch_freq_change_seq.sv ----
// Bench for dllsw_core: register port, DLL switching, power states, leveling.
// Assumes dllsw_ctrl_model drives the command side and the checker is bound.
`timescale 1ns/1ps
`include "dllsw_params.svh"
module tb_dll_switch_freq_change_seq;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic mrs_strobe, ck_level, dq0_out, dq0_oe, dq8_out, dq8_oe, dll_disabled, wlev_active;
  logic clk_ignored;
  logic [1:0] mrs_select, stb;
  logic [15:0] mrs_value;
  logic [3:0] ev;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  dllsw_ctrl_model m (.clk_sys, .mrs_strobe, .mrs_select, .mrs_value, .pwr_ev(ev), .ck_level,
    .stb);
  dllsw_core #(.DLLK_CYCLES(16'h0008)) dut (.clk_sys, .arst_n, .mrs_strobe, .mrs_select,
    .mrs_value, .sr_enter(ev[0]), .sr_exit(ev[1]), .pd_enter(ev[2]), .pd_exit(ev[3]), .ck_level,
    .lower_lane_strobe_pair(stb[0]), .upper_lane_strobe_pair(stb[1]), .dq0_out, .dq0_oe,
    .dq8_out, .dq8_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dll_disabled,
    .wlev_active, .clk_ignored);
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Settled sampling away from the launching edge
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    @(negedge clk_sys);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic t_dll();
    wr(`DLLSW_REG_LOCKCFG, 32'h20);
    rdr(`DLLSW_REG_LOCKCFG, rd);
    chk("lockcfg", 32'h20, rd);
    rdr(4'hF, rd);
    chk("unmapped", 32'h0, rd);
    m.mrs(`DLLSW_MR1_SEL, 16'h0001);
    chk("dll off", 32'h1, dll_disabled);
    m.mrs(`DLLSW_MRS_MR0, 16'h0100);
    rdr(`DLLSW_REG_STATUS, rd);
    chk("off status", 32'h1, rd & 32'hF);
    m.pwr(4'h1);
    chk("sr ignore", 32'h1, clk_ignored);
    m.pwr(4'h2);
    chk("sr resume", 32'h0, clk_ignored);
    m.mrs(`DLLSW_MR1_SEL, 16'h0000);
    chk("dll on", 32'h0, dll_disabled);
    m.mrs(`DLLSW_MRS_MR0, 16'h0100);
    rdr(`DLLSW_REG_STATUS, rd);
    chk("relock", 32'h4, rd & 32'hC);
    repeat (40) @(posedge clk_sys);
    rdr(`DLLSW_REG_STATUS, rd);
    chk("locked", 32'h8, rd & 32'hC);
    m.pwr(4'h4);
    rdr(`DLLSW_REG_STATUS, rd);
    chk("ppd", 32'h64, rd & 32'h7C);
    m.pwr(4'h8);
    m.mrs(`DLLSW_MRS_MR0, 16'h0100);
    rdr(`DLLSW_REG_STATUS, rd);
    chk("pd relock", 32'h4, rd & 32'h7C);
    repeat (40) @(posedge clk_sys);
    rdr(`DLLSW_REG_STATUS, rd);
    chk("pd locked", 32'h8, rd & 32'h7C);
  endtask
  task automatic t_wlev();
    int d;
    m.mrs(`DLLSW_MR1_SEL, 16'h0080);
    chk("oe", 32'h3, {dq8_oe, dq0_oe});
    chk("wlev on", 32'h1, wlev_active);
    for (d = 0; d < 8 && dq0_out !== 1'b1; d++) begin
      m.pulse(0, d >= 3);
    end
    chk("sweep", 32'h4, d);
    m.pulse(1, 1'b1);
    chk("both lanes", 32'h3, {dq8_out, dq0_out});
    m.pulse(0, 1'b0);
    chk("lower only", 32'h2, {dq8_out, dq0_out});
    rdr(`DLLSW_REG_STATUS, rd);
    chk("lower count", 32'h05000002, rd & 32'hFF000003);
    rdr(`DLLSW_REG_CTRL, rd);
    chk("mr1 shadow", 32'h80, rd);
    m.mrs(`DLLSW_MR1_SEL, 16'h0000);
    chk("oe off", 32'h0, {dq8_oe, dq0_oe});
    chk("wlev off", 32'h0, wlev_active);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_dll();
    t_wlev();
    results();
  end
endmodule
